//--- axis_flag_cell.sv
// One axis: fresh and overrun flags plus the latest sample store.
// Assumes set and clear are single-cycle strobes from the same clock.
`timescale 1ns/1ps
module axis_flag_cell (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wipe,
    input wire logic acquire,
    input wire logic [rate_flags_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic high_read,
    output logic fresh,
    output logic overrun,
    output logic [rate_flags_pkg::SAMPLE_W-1:0] sample
);

    // Fresh set wins over a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (!rst_b || wipe)
            fresh <= 1'b0;
        else if (acquire)
            fresh <= 1'b1;
        else if (high_read)
            fresh <= 1'b0;
    end

    // Overrun when new data lands on an unread sample
    always_ff @(posedge clk)
    begin
        if (!rst_b || wipe)
            overrun <= 1'b0;
        else if (acquire && fresh)
            overrun <= 1'b1;
        else if (high_read)
            overrun <= 1'b0;
    end

    // Always keep the latest acquisition
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            sample <= rate_flags_pkg::SAMPLE_RESET;
        else if (acquire)
            sample <= sample_in;
    end

endmodule

//--- host_reader.sv
// Host model that issues single register reads to the status block.
// Assumes the block loads read data on the edge that takes the strobe.
`timescale 1ns/1ps
module host_reader (
    input wire logic clk,
    output rate_flags_pkg::reg_read_s host_read,
    input wire logic [7:0] read_data
);
    initial host_read = '0;

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        host_read = '{strobe: 1'b1, addr: addr};
        @(negedge clk);
        data = read_data;
        host_read.strobe = 1'b0;
        // Address no longer qualified, so show something else
        host_read.addr = ~addr;
    endtask

    task automatic read_axis(input logic [7:0] high_addr, output logic [15:0] word);
        read_reg(high_addr, word[15:8]);
        read_reg(high_addr + 8'h01, word[7:0]);
    endtask
endmodule

//--- rate_flags_pkg.sv
// Shared constants and carriers for the sample-ready status logic.
// Assumes one 25 MHz clock domain; no imports, every use is scoped.
package rate_flags_pkg;

    // ****************************************
    // Status bit positions, axis count and sample width
    // ****************************************
    localparam int X_FRESH_BIT = 0;
    localparam int Y_FRESH_BIT = 1;
    localparam int Z_FRESH_BIT = 2;
    localparam int ANY_FRESH_BIT = 3;
    localparam int X_OVERRUN_BIT = 4;
    localparam int Y_OVERRUN_BIT = 5;
    localparam int Z_OVERRUN_BIT = 6;
    localparam int ALL_OVERRUN_BIT = 7;
    localparam int AXES = 3;
    localparam int SAMPLE_W = 16;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [7:0] OUT_X_HIGH_ADDR = 8'h01;
    localparam logic [7:0] OUT_X_LOW_ADDR = 8'h02;
    localparam logic [7:0] OUT_Y_HIGH_ADDR = 8'h03;
    localparam logic [7:0] OUT_Y_LOW_ADDR = 8'h04;
    localparam logic [7:0] OUT_Z_HIGH_ADDR = 8'h05;
    localparam logic [7:0] OUT_Z_LOW_ADDR = 8'h06;
    localparam logic [7:0] SAMPLE_READY_STATUS_ADDR = 8'h07;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] SAMPLE_RESET = 16'h0000;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_READY = 2'b01,
        MODE_ACTIVE = 2'b10
    } op_mode_e;

    // Host register read strobe with its address
    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
    } reg_read_s;

endpackage

//--- rate_sample_ready_flags.sv
// Sample-ready status flags for a three-axis rate sensor core.
// Assumes acquisitions, mode and host read strobes share the 25 MHz clock.
// What this block does
// - Z overrun, bit 6, sets on Z data over unread Z; clears on Z high read.
// - Y overrun, bit 5, sets on Y data over unread Y; clears on Y high read.
// - X overrun, bit 4, sets on X data over unread X; clears on X high read.
// - On overrun the newer sample replaces the unread older one.
// - Combined fresh flag, bit 3, sets when any axis gets new data.
// - Combined fresh flag clears once every axis with new data has had its high byte read.
// - Z fresh, bit 2, sets on Z acquisition, clears on Z high read.
// - Y fresh, bit 1, sets on Y acquisition, clears on Y high read.
// - X fresh, bit 0, sets on X acquisition, clears on X high read.
// - Combined overrun, bit 7, sets on a full set over an unread set.
// - All flags clear on entry into active mode from standby or ready.
`timescale 1ns/1ps
module rate_sample_ready_flags (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire rate_flags_pkg::op_mode_e MODE,
    input wire logic [2:0] ACQUIRE,
    input wire logic [rate_flags_pkg::SAMPLE_W-1:0] X_SAMPLE,
    input wire logic [rate_flags_pkg::SAMPLE_W-1:0] Y_SAMPLE,
    input wire logic [rate_flags_pkg::SAMPLE_W-1:0] Z_SAMPLE,
    input wire rate_flags_pkg::reg_read_s HOST_READ,
    output logic [7:0] SAMPLE_READY_STATUS,
    output logic [7:0] READ_DATA
);

    // ****************************************
    // Mode entry and read decode
    // ****************************************
    rate_flags_pkg::op_mode_e last_mode;
    logic wipe;
    logic [2:0] high_read;
    logic [2:0] fresh;
    logic [2:0] overrun;
    logic [rate_flags_pkg::SAMPLE_W-1:0] sample [3];
    logic [rate_flags_pkg::SAMPLE_W-1:0] sample_in [3];
    logic [2:0] read_pending;
    logic [2:0] set_pending;
    logic any_fresh;
    logic all_overrun;
    logic [2:0] owed_after;
    logic [2:0] set_unread;
    logic [7:0] low_shadow [3];
    logic [7:0] next_status;
    logic [7:0] next_read_data;
    logic full_set;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_B)
            last_mode <= rate_flags_pkg::MODE_STANDBY;
        else
            last_mode <= MODE;
    end

    assign wipe = (MODE == rate_flags_pkg::MODE_ACTIVE) &&
                  (last_mode != rate_flags_pkg::MODE_ACTIVE);

    assign high_read[0] = HOST_READ.strobe &&
                          (HOST_READ.addr == rate_flags_pkg::OUT_X_HIGH_ADDR);
    assign high_read[1] = HOST_READ.strobe &&
                          (HOST_READ.addr == rate_flags_pkg::OUT_Y_HIGH_ADDR);
    assign high_read[2] = HOST_READ.strobe &&
                          (HOST_READ.addr == rate_flags_pkg::OUT_Z_HIGH_ADDR);
    assign sample_in[0] = X_SAMPLE;
    assign sample_in[1] = Y_SAMPLE;
    assign sample_in[2] = Z_SAMPLE;

    // ****************************************
    // Per-axis flags
    // ****************************************
    // axis flags
    generate
        for (genvar a = 0; a < rate_flags_pkg::AXES; a++)
        begin : g_axis
            axis_flag_cell u_cell (
                .clk(CLOCK),
                .rst_b(RST_B),
                .wipe(wipe),
                .acquire(ACQUIRE[a]),
                .sample_in(sample_in[a]),
                .high_read(high_read[a]),
                .fresh(fresh[a]),
                .overrun(overrun[a]),
                .sample(sample[a])
            );
        end
    endgenerate

    // ****************************************
    // Combined flags
    // ****************************************
    // Axes whose high byte is still owed since the combined flag rose
    always_ff @(posedge CLOCK)
    begin
        if (!RST_B || wipe)
            read_pending <= 3'b000;
        else
            read_pending <= (read_pending & ~high_read) | ACQUIRE;
    end

    assign owed_after = read_pending & ~high_read;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_B || wipe)
            any_fresh <= 1'b0;
        else if (|ACQUIRE)
            any_fresh <= 1'b1;
        else if (any_fresh && (owed_after == 3'b000))
            any_fresh <= 1'b0;
    end

    // Axes acquired since the last full set completed
    assign full_set = &(set_pending | ACQUIRE);

    always_ff @(posedge CLOCK)
    begin
        if (!RST_B || wipe || full_set)
            set_pending <= 3'b000;
        else
            set_pending <= set_pending | ACQUIRE;
    end

    // Axes of the last full set whose high byte is still unread
    always_ff @(posedge CLOCK)
    begin
        if (!RST_B || wipe)
            set_unread <= 3'b000;
        else if (full_set)
            set_unread <= 3'b111;
        else
            set_unread <= set_unread & ~high_read;
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_B || wipe)
            all_overrun <= 1'b0;
        else if (full_set && (set_unread != 3'b000))
            all_overrun <= 1'b1;
        else if (all_overrun && (owed_after == 3'b000))
            all_overrun <= 1'b0;
    end

    // ****************************************
    // Register read path
    // ****************************************
    // low byte follows high byte read
    always_ff @(posedge CLOCK)
    begin
        if (!RST_B)
        begin
            low_shadow[0] <= 8'h00;
            low_shadow[1] <= 8'h00;
            low_shadow[2] <= 8'h00;
        end
        else
        begin
            for (int a = 0; a < 3; a++)
                if (high_read[a])
                    low_shadow[a] <= sample[a][7:0];
        end
    end

    always_comb
    begin
        next_status = {all_overrun, overrun, any_fresh, fresh};
        next_read_data = 8'h00;
        case (HOST_READ.addr)
            rate_flags_pkg::OUT_X_HIGH_ADDR: next_read_data = sample[0][15:8];
            rate_flags_pkg::OUT_X_LOW_ADDR: next_read_data = low_shadow[0];
            rate_flags_pkg::OUT_Y_HIGH_ADDR: next_read_data = sample[1][15:8];
            rate_flags_pkg::OUT_Y_LOW_ADDR: next_read_data = low_shadow[1];
            rate_flags_pkg::OUT_Z_HIGH_ADDR: next_read_data = sample[2][15:8];
            rate_flags_pkg::OUT_Z_LOW_ADDR: next_read_data = low_shadow[2];
            rate_flags_pkg::SAMPLE_READY_STATUS_ADDR: next_read_data = next_status;
            default: next_read_data = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_B)
            SAMPLE_READY_STATUS <= rate_flags_pkg::STATUS_RESET;
        else
            SAMPLE_READY_STATUS <= next_status;
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_B)
            READ_DATA <= 8'h00;
        else if (HOST_READ.strobe)
            READ_DATA <= next_read_data;
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_z_unread_acq;
        fresh[2] && ACQUIRE[2];
    endsequence

    a_z_overrun_set: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_z_unread_acq and !wipe |=> overrun[2])
        else $error("Z overrun not set");
    a_y_overrun_set: assert property (@(posedge CLOCK) disable iff (!RST_B)
        fresh[1] && ACQUIRE[1] && !wipe |=> overrun[1])
        else $error("Y overrun not set");
    a_x_overrun_clr: assert property (@(posedge CLOCK) disable iff (!RST_B)
        high_read[0] && !ACQUIRE[0] |=> !overrun[0])
        else $error("X overrun not cleared");
    a_sample_latest: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ACQUIRE[2] |=> sample[2] == $past(Z_SAMPLE))
        else $error("Z sample not replaced");
    a_any_fresh_set: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (|ACQUIRE) && !wipe |=> any_fresh ##1 SAMPLE_READY_STATUS[3])
        else $error("Combined fresh not set");
    a_any_fresh_hold: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $fell(any_fresh) |-> $past(wipe) || $past(owed_after) == 3'b000)
        else $error("Combined fresh cleared early");
    a_z_fresh_clr: assert property (@(posedge CLOCK) disable iff (!RST_B)
        high_read[2] && !ACQUIRE[2] |=> !fresh[2])
        else $error("Z fresh not cleared");
    a_y_fresh_set: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ACQUIRE[1] && !wipe |=> fresh[1] ##1 SAMPLE_READY_STATUS[1])
        else $error("Y fresh not set");
    a_x_fresh_win: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ACQUIRE[0] && high_read[0] && !wipe |=> fresh[0])
        else $error("X fresh lost on clash");
    a_all_overrun: assert property (@(posedge CLOCK) disable iff (!RST_B)
        full_set && set_unread != 3'b000 && !wipe |=> all_overrun)
        else $error("Combined overrun not set");
    a_mode_wipe: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wipe |=> ##1 SAMPLE_READY_STATUS == 8'h00 || $past(ACQUIRE) != 3'b000)
        else $error("Status not wiped on active entry");

endmodule

//--- tb.sv
// Self-checking bench for the sample-ready status flags.
// Assumes host_reader drives the read strobe; inputs change at falling edges.
`timescale 1ns/1ps
module tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    rate_flags_pkg::op_mode_e MODE = rate_flags_pkg::MODE_STANDBY;
    rate_flags_pkg::op_mode_e idle_modes [2] = '{rate_flags_pkg::MODE_STANDBY,
                                                 rate_flags_pkg::MODE_READY};
    logic [2:0] ACQUIRE = 3'b000;
    logic [15:0] smp = 16'h0000;
    rate_flags_pkg::reg_read_s HOST_READ;
    logic [7:0] SAMPLE_READY_STATUS;
    logic [7:0] READ_DATA;
    logic [15:0] word;
    int err_total = 0;
    int num_checks = 0;

    always #20 CLOCK = ~CLOCK;

    rate_sample_ready_flags rate_sample_ready_flags_i (.CLOCK(CLOCK), .RST_B(RST_B),
        .MODE(MODE), .ACQUIRE(ACQUIRE), .X_SAMPLE(smp), .Y_SAMPLE(~smp), .Z_SAMPLE(smp),
        .HOST_READ(HOST_READ), .SAMPLE_READY_STATUS(SAMPLE_READY_STATUS),
        .READ_DATA(READ_DATA));
    host_reader host_reader_i (.clk(CLOCK), .host_read(HOST_READ), .read_data(READ_DATA));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Status port lags the flags by one cycle
    task automatic status_is(input logic [7:0] exp);
        @(negedge CLOCK);
        chk({8'h00, SAMPLE_READY_STATUS}, {8'h00, exp});
    endtask

    task automatic acq(input logic [2:0] axes, input logic [15:0] val);
        @(negedge CLOCK);
        ACQUIRE = axes;
        smp = val;
        @(negedge CLOCK);
        ACQUIRE = 3'b000;
        smp = ~val;
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (12) @(negedge CLOCK);
        RST_B = 1'b1;
        MODE = rate_flags_pkg::MODE_ACTIVE;
        @(negedge CLOCK);
        status_is(8'h00);
        acq(3'b001, 16'hA51C);
        status_is(8'h09);
        host_reader_i.read_axis(rate_flags_pkg::OUT_X_HIGH_ADDR, word);
        chk(word, 16'hA51C);
        status_is(8'h00);
        acq(3'b010, 16'h1234);
        acq(3'b010, 16'h5678);
        status_is(8'h2A);
        host_reader_i.read_axis(rate_flags_pkg::OUT_Y_HIGH_ADDR, word);
        chk(word, ~16'h5678);
        status_is(8'h00);
        acq(3'b111, 16'h0F0F);
        acq(3'b111, 16'hC3C3);
        status_is(8'hFF);
        host_reader_i.read_reg(rate_flags_pkg::SAMPLE_READY_STATUS_ADDR, word[7:0]);
        chk({8'h00, word[7:0]}, 16'h00FF);
        host_reader_i.read_axis(rate_flags_pkg::OUT_X_HIGH_ADDR, word);
        chk(word, 16'hC3C3);
        status_is(8'hEE);
        host_reader_i.read_axis(rate_flags_pkg::OUT_Y_HIGH_ADDR, word);
        chk(word, ~16'hC3C3);
        status_is(8'hCC);
        host_reader_i.read_axis(rate_flags_pkg::OUT_Z_HIGH_ADDR, word);
        chk(word, 16'hC3C3);
        status_is(8'h00);
        // Acquisition and high-byte read taken at the same edge
        fork
            acq(3'b001, 16'h7E81);
            host_reader_i.read_reg(rate_flags_pkg::OUT_X_HIGH_ADDR, word[7:0]);
        join
        status_is(8'h09);
        host_reader_i.read_axis(rate_flags_pkg::OUT_X_HIGH_ADDR, word);
        chk(word, 16'h7E81);
        status_is(8'h00);
        for (int i = 0; i < 2; i++)
        begin
            acq(3'b100, 16'h00FF);
            status_is(8'h0C);
            MODE = idle_modes[i];
            repeat (2) @(negedge CLOCK);
            MODE = rate_flags_pkg::MODE_ACTIVE;
            @(negedge CLOCK);
            status_is(8'h00);
        end
        host_reader_i.read_reg(8'h20, word[7:0]);
        chk({8'h00, word[7:0]}, 16'h0000);
        report_and_stop();
    end

    // Tests need about 80 cycles; 2000 cycles means a hang
    initial
    begin
        #(40 * 2000);
        err_total++;
        report_and_stop();
    end
endmodule
